// >>> core/timer_core.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "timer_defines.svh"

module timer_core (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic tmr_in_i,
    output logic tmr_out_o,
    output logic tmr_out_n_o
);
    import timer_pkg::*;

    timer_state_s st_q;
    timer_state_s st_d;

    logic tick;
    logic [3:0] mode;
    logic pol;
    logic en;
    logic oe;
    logic [31:0] mask;
    logic at_cmp;
    logic [31:0] inc;
    logic rise;
    logic fall;
    logic sel_edge;
    logic active;
    logic irq_set;
    logic addr_ok;
    logic sw_cnt_wr;
    logic sw_irq_clr;

    // Counter arithmetic follows the configured width.
    function automatic logic [31:0] width_mask(input logic cascade);
        width_mask = cascade ? `MASK_CASCADED : `MASK_DUAL_HALF;
    endfunction

    function automatic logic [31:0] read_reg(input timer_state_s s,
                                             input logic [7:0] a);
        case (a)
            `OFS_COUNTER_VALUE: read_reg = s.cnt;
            `OFS_COMPARE_VALUE: read_reg = s.cmp;
            `OFS_MATCH_OR_CAPTURE: read_reg = s.cap;
            `OFS_INTERRUPT_FLAGS: read_reg = {31'h0, s.irq};
            `OFS_CONTROL_PRIMARY: read_reg = s.ctrl0;
            `OFS_NON_OVERLAP_COMPARE: read_reg = s.nolcmp;
            `OFS_CONFIGURATION: read_reg = s.ctrl1;
            default: read_reg = 32'h0000_0000;
        endcase
    endfunction

    assign mode = st_q.ctrl0[`MODE_SELECT_MSB:`MODE_SELECT_LSB];
    assign pol = st_q.ctrl0[`POLARITY_SELECT_BIT];
    assign en = st_q.ctrl0[`TIMER_ENABLE_BIT];
    assign oe = st_q.ctrl0[`OUTPUT_ENABLE_BIT];
    assign mask = width_mask(st_q.ctrl1[`CASCADE_SELECT_BIT]);
    assign at_cmp = ((st_q.cnt & mask) == (st_q.cmp & mask));
    assign inc = (st_q.cnt + 32'h0000_0001) & mask;
    assign rise = tmr_in_i & ~st_q.in_prev;
    assign fall = ~tmr_in_i & st_q.in_prev;
    assign active = (tmr_in_i != pol);
    assign addr_ok = hsel_i & htrans_i[1] & hready_i;
    assign sw_cnt_wr = st_q.wr_pend && (st_q.wr_addr == `OFS_COUNTER_VALUE);
    assign sw_irq_clr = st_q.wr_pend
                        && (st_q.wr_addr == `OFS_INTERRUPT_FLAGS)
                        && hwdata_i[`INTERRUPT_FLAG_BIT];

    always_comb begin
        if (mode == `MODE_DUAL_EDGE) begin
            sel_edge = rise | fall;
        end else begin
            sel_edge = pol ? rise : fall;
        end
    end

    timer_prescaler u_prescaler (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(en),
        .pres_i(st_q.ctrl0[`PRESCALE_SELECT_MSB:`PRESCALE_SELECT_LSB]),
        .tick_o(tick)
    );

    always_comb begin
        st_d = st_q;
        irq_set = 1'b0;

        // Bus slave: writes take effect in the data phase with no wait state;
        // reads add one wait state so a read never sees a stale write.
        st_d.wr_pend = 1'b0;
        st_d.rd_pend = 1'b0;
        st_d.ready = 1'b1;
        st_d.resp = `AHB_RESP_OKAY;
        if (addr_ok) begin
            if (hwrite_i) begin
                st_d.wr_pend = (hsize_i == `AHB_SIZE_WORD);
                st_d.wr_addr = haddr_i[7:0];
            end else begin
                st_d.rd_pend = 1'b1;
                st_d.rd_addr = haddr_i[7:0];
                st_d.ready = 1'b0;
            end
        end
        if (st_q.rd_pend) begin
            st_d.rdata = read_reg(st_q, st_q.rd_addr);
        end

        // Counting engine, advanced once per timer clock tick.
        if (!en) begin
            st_d.in_prev = tmr_in_i;
            st_d.cst = CAP_WAIT;
            st_d.tog = pol;
        end else if (tick) begin
            st_d.in_prev = tmr_in_i;
            case (mode)
                `MODE_COMPARE: begin
                    if (at_cmp) begin
                        st_d.cnt = `RESTART_COMPARE;
                        irq_set = 1'b1;
                        st_d.tog = ~st_q.tog;
                    end else begin
                        st_d.cnt = inc;
                    end
                end
                `MODE_GATED, `MODE_INACTIVE_GATED: begin
                    if (active) begin
                        if (at_cmp) begin
                            st_d.cnt = `RESTART_OTHER;
                            st_d.tog = ~st_q.tog;
                            irq_set = (mode == `MODE_GATED);
                        end else begin
                            st_d.cnt = inc;
                        end
                    end else if (mode == `MODE_INACTIVE_GATED) begin
                        irq_set = 1'b1;
                    end
                end
                `MODE_CAPTURE_COMPARE, `MODE_DUAL_EDGE: begin
                    if (st_q.cst == CAP_WAIT) begin
                        // The arming edge counts for nothing else.
                        if (sel_edge) begin
                            st_d.cst = CAP_RUN;
                        end
                    end else if (sel_edge) begin
                        st_d.cap = st_q.cnt;
                        st_d.cnt = `RESTART_OTHER;
                        irq_set = 1'b1;
                    end else if (at_cmp) begin
                        st_d.cnt = `RESTART_OTHER;
                        irq_set = 1'b1;
                    end else begin
                        st_d.cnt = inc;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register writes; a count written while idle seeds only the first
        // period, since every period end reloads the fixed restart value.
        if (st_q.wr_pend) begin
            case (st_q.wr_addr)
                `OFS_COUNTER_VALUE: st_d.cnt = hwdata_i;
                `OFS_COMPARE_VALUE: st_d.cmp = hwdata_i;
                `OFS_MATCH_OR_CAPTURE: st_d.cap = hwdata_i;
                `OFS_CONTROL_PRIMARY: st_d.ctrl0 = hwdata_i;
                `OFS_NON_OVERLAP_COMPARE: st_d.nolcmp = hwdata_i;
                `OFS_CONFIGURATION: st_d.ctrl1 = hwdata_i;
                default: begin
                end
            endcase
        end

        // A new event in the clearing cycle keeps the flag set.
        st_d.irq = irq_set | (st_q.irq & ~sw_irq_clr);

        // Unless the output is enabled, tmr_out_o rests at the polarity level and tmr_out_n_o at its inverse.
        st_d.pin = oe ? st_d.tog : pol;
        st_d.pin_n = oe ? ~st_d.tog : ~pol;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_q <= '0;
            st_q.cnt <= `RST_COUNTER_VALUE;
            st_q.cmp <= `RST_COMPARE_VALUE;
            st_q.ctrl0 <= `RST_CONTROL_PRIMARY;
            st_q.ctrl1 <= `RST_CONFIGURATION;
            st_q.pin_n <= 1'b1;
            st_q.ready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign hrdata_o = st_q.rdata;
    assign hreadyout_o = st_q.ready;
    assign hresp_o = st_q.resp;
    assign tmr_out_o = st_q.pin;
    assign tmr_out_n_o = st_q.pin_n;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    logic run_tick;
    assign run_tick = en && tick && !sw_cnt_wr;

    sequence s_read_req;
        addr_ok && !hwrite_i;
    endsequence

    sequence s_read_answer;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    chk_cmp_restart: assert property (
        run_tick && mode == `MODE_COMPARE && at_cmp
        |=> st_q.cnt == 32'h0000_0000 && st_q.irq)
        else $error("compare period did not restart at zero");

    chk_cmp_toggle: assert property (
        run_tick && mode == `MODE_COMPARE && at_cmp
        |=> st_q.tog != $past(st_q.tog))
        else $error("compare period did not toggle output");

    chk_inv_pin: assert property (
        tmr_out_n_o == ~tmr_out_o)
        else $error("inverted output is not the complement");

    chk_gate_hold: assert property (
        run_tick && mode == `MODE_GATED && !active
        |=> $stable(st_q.cnt))
        else $error("gated counter moved while input inactive");

    chk_gate_reload: assert property (
        run_tick && mode == `MODE_GATED && active && at_cmp
        |=> st_q.cnt == 32'h0000_0001 && st_q.irq
            && st_q.tog != $past(st_q.tog))
        else $error("gated period end did not reload one");

    chk_cap_idle: assert property (
        run_tick && mode == `MODE_CAPTURE_COMPARE
        && st_q.cst == CAP_WAIT
        |=> $stable(st_q.cnt))
        else $error("capture counter ran before first edge");

    chk_cap_load: assert property (
        run_tick && mode == `MODE_CAPTURE_COMPARE
        && st_q.cst == CAP_RUN && sel_edge
        && !(st_q.wr_pend && st_q.wr_addr == `OFS_MATCH_OR_CAPTURE)
        |=> st_q.cap == $past(st_q.cnt) && st_q.cnt == 32'h0000_0001
            && st_q.irq)
        else $error("capture did not store count and reload");

    chk_first_edge: assert property (
        en && tick && st_q.cst == CAP_WAIT && sel_edge && !st_q.irq
        && (mode == `MODE_CAPTURE_COMPARE || mode == `MODE_DUAL_EDGE)
        |=> !st_q.irq && st_q.cst == CAP_RUN)
        else $error("first edge raised the flag");

    chk_irq_setwin: assert property (
        irq_set && sw_irq_clr |=> st_q.irq)
        else $error("flag lost when set and clear coincide");

    chk_bus_read: assert property (
        s_read_req |=> s_read_answer)
        else $error("read answer not given after one wait state");

endmodule // timer_core

// >>> shared/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Register byte offsets.
`define OFS_COUNTER_VALUE 8'h00
`define OFS_COMPARE_VALUE 8'h04
`define OFS_MATCH_OR_CAPTURE 8'h08
`define OFS_INTERRUPT_FLAGS 8'h0c
`define OFS_CONTROL_PRIMARY 8'h10
`define OFS_NON_OVERLAP_COMPARE 8'h14
`define OFS_CONFIGURATION 8'h18
`define OFS_WAKEUP_STATUS 8'h1c

// Field positions in control_primary.
`define MODE_SELECT_LSB 0
`define MODE_SELECT_MSB 3
`define PRESCALE_SELECT_LSB 4
`define PRESCALE_SELECT_MSB 7
`define POLARITY_SELECT_BIT 8
`define TIMER_ENABLE_BIT 9
`define OUTPUT_ENABLE_BIT 10

// Field positions in configuration and interrupt_flags.
`define CASCADE_SELECT_BIT 0
`define INTERRUPT_ENABLE_BIT 1
`define INTERRUPT_FLAG_BIT 0

// Mode codes.
`define MODE_COMPARE 4'h5
`define MODE_GATED 4'h6
`define MODE_CAPTURE_COMPARE 4'h7
`define MODE_DUAL_EDGE 4'h8
`define MODE_INACTIVE_GATED 4'he

// Reset and restart values, and counter width masks.
`define RST_COUNTER_VALUE 32'h0000_0000
`define RST_COMPARE_VALUE 32'h0000_0000
`define RST_CONTROL_PRIMARY 32'h0000_0000
`define RST_CONFIGURATION 32'h0000_0001
`define RESTART_COMPARE 32'h0000_0000
`define RESTART_OTHER 32'h0000_0001
`define MASK_CASCADED 32'hffff_ffff
`define MASK_DUAL_HALF 32'h0000_ffff

// Bus encodings.
`define AHB_SIZE_WORD 3'h2
`define AHB_RESP_OKAY 1'h0

`endif

// >>> shared/timer_pkg.sv
package timer_pkg;

    typedef enum logic {
        CAP_WAIT,
        CAP_RUN
    } cap_state_e;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } prescale_state_s;

    typedef struct packed {
        logic [31:0] cnt;
        logic [31:0] cmp;
        logic [31:0] cap;
        logic [31:0] nolcmp;
        logic [31:0] ctrl0;
        logic [31:0] ctrl1;
        logic irq;
        cap_state_e cst;
        logic in_prev;
        logic tog;
        logic pin;
        logic pin_n;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic rd_pend;
        logic [7:0] rd_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } timer_state_s;

endpackage

// >>> core/timer_prescaler.sv
`timescale 1ns/1ps
`include "timer_defines.svh"

module timer_prescaler (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic [3:0] pres_i,
    output logic tick_o
);
    import timer_pkg::*;

    prescale_state_s st_q;
    prescale_state_s st_d;
    logic [15:0] limit;

    // The timer clock is one tick every two to the power of pres_i cycles.
    always_comb begin
        limit = (16'h0001 << pres_i) - 16'h0001;
        st_d = st_q;
        st_d.tick = 1'b0;
        if (!en_i) begin
            st_d.cnt = 16'h0000;
        end else if (st_q.cnt >= limit) begin
            st_d.cnt = 16'h0000;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick;

endmodule // timer_prescaler

// >>> tb/timer_pin_model.sv
`timescale 1ns/1ps

module timer_pin_model (
    input wire logic clk_i,
    input wire logic tmr_out_i,
    output logic tmr_in_o,
    output int toggles_o,
    output int gap_o
);
    int run;
    logic last;

    initial begin
        tmr_in_o = 1'b0;
        toggles_o = 0;
        gap_o = 0;
        run = 0;
        last = 1'b0;
    end

    // The input pin is a driven level, so it never floats between commands.
    task automatic drive(input logic v);
        @(posedge clk_i);
        tmr_in_o <= v;
    endtask

    // Clocks between output changes give the length of each timer period.
    always @(posedge clk_i) begin
        run <= run + 1;
        if (tmr_out_i !== last) begin
            last <= tmr_out_i;
            gap_o <= run + 1;
            run <= 0;
            toggles_o <= toggles_o + 1;
        end
    end
endmodule // timer_pin_model

// >>> tb/tb_timer_compare_gated_capture_modes.sv
`timescale 1ns/1ps
`include "timer_defines.svh"

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end end

module tb_timer_compare_gated_capture_modes;
    logic clk_i, nrst_i, hsel, hwrite, hready, hresp, tmr_in, tmr_out, tmr_n;
    logic hsl;
    logic [2:0] hsize, hsz;
    logic [31:0] haddr, hwdata, hrdata, rd, cap;
    logic [1:0] htrans;
    int bad_count, n_checks, seed, toggles, gap, c, n, cv;
    logic [31:0] rst_tab [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                                 32'h1, 32'h0, 32'h0};

    timer_core timer_core_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .tmr_in_i(tmr_in), .tmr_out_o(tmr_out),
        .tmr_out_n_o(tmr_n));

    timer_pin_model timer_pin_model_inst (.clk_i(clk_i),
        .tmr_out_i(tmr_out), .tmr_in_o(tmr_in), .toggles_o(toggles),
        .gap_o(gap));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1) begin
            bad_count++;
            close_out();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel <= hsl;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= hsz;
        // Only the low byte is decoded, so the upper bits are left random.
        haddr <= {24'($random(seed)), a};
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        `CHK("resp", `AHB_RESP_OKAY, hresp)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task automatic rdf(input logic [7:0] a);
        bus(1'b0, a, 32'h0, rd);
    endtask

    // Every change is made with the timer stopped, as software must do.
    task automatic setup(input logic [31:0] ctl, cmp, cnt, cfg);
        wr(`OFS_CONTROL_PRIMARY, 32'h0);
        wr(`OFS_CONFIGURATION, cfg);
        wr(`OFS_COMPARE_VALUE, cmp);
        wr(`OFS_COUNTER_VALUE, cnt);
        wr(`OFS_INTERRUPT_FLAGS, 32'h1);
        wr(`OFS_CONTROL_PRIMARY, ctl);
    endtask

    task automatic wait_tog(input int k);
        c = toggles + k;
        n = 0;
        while (toggles < c && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        if (toggles < c) begin
            bad_count++;
            close_out();
        end
    endtask

    task automatic pause(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    function automatic logic [31:0] ctl(input logic [3:0] m, p,
                                        input logic pl);
        return {21'h0, 2'h3, pl, p, m};
    endfunction

    // Compare mode restarts at zero, the others at one.
    function automatic int period(input logic [3:0] m, input int cmp, p);
        return (m == `MODE_COMPARE ? cmp + 1 : cmp) << p;
    endfunction

    initial begin
        seed = 73894;
        bad_count = 0;
        n_checks = 0;
        nrst_i = 1'b0;
        hsel = 1'b0;
        hsl = 1'b1;
        hsize = `AHB_SIZE_WORD;
        hsz = `AHB_SIZE_WORD;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        pause(12);
        nrst_i <= 1'b1;
        foreach (rst_tab[i]) begin
            rdf(8'(i * 4));
            `CHK("reset value", rst_tab[i], rd)
        end
        cap = $random(seed);
        wr(`OFS_NON_OVERLAP_COMPARE, cap);
        wr(`OFS_WAKEUP_STATUS, cap);
        rdf(`OFS_NON_OVERLAP_COMPARE);
        `CHK("storage", cap, rd)
        hsz = 3'h1;
        wr(`OFS_NON_OVERLAP_COMPARE, ~cap);
        hsz = `AHB_SIZE_WORD;
        hsl = 1'b0;
        wr(`OFS_NON_OVERLAP_COMPARE, ~cap);
        hsl = 1'b1;
        rdf(`OFS_NON_OVERLAP_COMPARE);
        `CHK("ignored writes", cap, rd)
        rdf(`OFS_WAKEUP_STATUS);
        `CHK("wakeup", 32'h0, rd)
        $display("TEST registers done");
        for (int p = 0; p < 3; p++) begin
            cv = 4 + $unsigned($random(seed)) % 8;
            setup(ctl(`MODE_COMPARE, 4'(p), 1'b0), cv, 0, 32'h3);
            wait_tog(2);
            `CHK("cmp period", period(`MODE_COMPARE, cv, p), gap)
            `CHK("inverted", ~tmr_out, tmr_n)
        end
        rdf(`OFS_INTERRUPT_FLAGS);
        `CHK("cmp flag", 32'h1, rd)
        setup(ctl(`MODE_COMPARE, 4'h0, 1'b0), 40, 38, 32'h3);
        wait_tog(1);
        `CHK("first period short", 1'b1, n < 8)
        wait_tog(1);
        `CHK("later period", 41, gap)
        setup(ctl(`MODE_COMPARE, 4'h0, 1'b0), 32'h0001_0005, 0, 32'h2);
        wait_tog(2);
        `CHK("half width", 6, gap)
        // With the output disabled the pin rests at the polarity level.
        setup(ctl(`MODE_COMPARE, 4'h0, 1'b1) ^ (32'h1 << `OUTPUT_ENABLE_BIT),
              3, 0, 32'h3);
        pause(20);
        `CHK("pin held", 1'b1, tmr_out)
        rdf(`OFS_INTERRUPT_FLAGS);
        `CHK("flag without pin", 32'h1, rd)
        $display("TEST compare done");
        timer_pin_model_inst.drive(1'b1);
        cv = 4 + $unsigned($random(seed)) % 8;
        setup(ctl(`MODE_GATED, 4'h0, 1'b0), cv, 0, 32'h3);
        wait_tog(2);
        `CHK("gated period", period(`MODE_GATED, cv, 0), gap)
        timer_pin_model_inst.drive(1'b0);
        pause(3);
        rdf(`OFS_COUNTER_VALUE);
        cap = rd;
        pause(20);
        rdf(`OFS_COUNTER_VALUE);
        `CHK("gated hold", cap, rd)
        setup(ctl(`MODE_INACTIVE_GATED, 4'h0, 1'b0), 1000, 0, 32'h3);
        pause(4);
        rdf(`OFS_INTERRUPT_FLAGS);
        `CHK("inactive flag", 32'h1, rd)
        timer_pin_model_inst.drive(1'b1);
        pause(3);
        wr(`OFS_INTERRUPT_FLAGS, 32'h1);
        rdf(`OFS_INTERRUPT_FLAGS);
        `CHK("active no flag", 32'h0, rd)
        $display("TEST gated done");
        for (int pl = 0; pl < 2; pl++) begin
            timer_pin_model_inst.drive(!pl);
            setup(ctl(`MODE_CAPTURE_COMPARE, 4'h0, 1'(pl)), 1000, 0, 32'h3);
            pause(10);
            rdf(`OFS_COUNTER_VALUE);
            `CHK("idle count", 32'h0, rd)
            timer_pin_model_inst.drive(1'(pl));
            pause(4);
            timer_pin_model_inst.drive(!pl);
            pause(4);
            rdf(`OFS_INTERRUPT_FLAGS);
            `CHK("arm no flag", 32'h0, rd)
            cv = 10 + $unsigned($random(seed)) % 30;
            pause(cv);
            timer_pin_model_inst.drive(1'(pl));
            pause(4);
            rdf(`OFS_MATCH_OR_CAPTURE);
            cap = rd;
            `CHK("capture", 1'b1, cap > cv && cap < cv + 30)
            rdf(`OFS_INTERRUPT_FLAGS);
            `CHK("capture flag", 32'h1, rd)
            rdf(`OFS_COUNTER_VALUE);
            `CHK("reload", 1'b1, rd > 1 && rd < cap)
        end
        timer_pin_model_inst.drive(1'b0);
        setup(ctl(`MODE_DUAL_EDGE, 4'h0, 1'b1), 1000, 0, 32'h3);
        timer_pin_model_inst.drive(1'b1);
        pause(4);
        timer_pin_model_inst.drive(1'b0);
        pause(4);
        rdf(`OFS_INTERRUPT_FLAGS);
        `CHK("dual edge flag", 32'h1, rd)
        setup(ctl(`MODE_CAPTURE_COMPARE, 4'h0, 1'b1), 6, 0, 32'h3);
        timer_pin_model_inst.drive(1'b1);
        pause(30);
        rdf(`OFS_INTERRUPT_FLAGS);
        `CHK("rollover flag", 32'h1, rd)
        rdf(`OFS_COUNTER_VALUE);
        `CHK("rollover count", 1'b1, rd >= 1 && rd <= 6)
        $display("TEST capture done");
        nrst_i <= 1'b0;
        pause(2);
        nrst_i <= 1'b1;
        rdf(`OFS_CONTROL_PRIMARY);
        `CHK("ctrl after reset", 32'h0, rd)
        rdf(`OFS_NON_OVERLAP_COMPARE);
        `CHK("storage after reset", 32'h0, rd)
        $display("TEST reset done");
        close_out();
    end
endmodule // tb_timer_compare_gated_capture_modes
